// ### eq_coeff_pkg.sv
// Constants and types for the channel B equalizer coefficient store.
// Assumes a 100 MHz APB clock; registers sit one per aligned 32-bit word.
package eq_coeff_pkg;

  // Printed register indexes; byte address is four times the index
  localparam logic [15:0] TAP1_IDX = 16'h0448;
  localparam logic [15:0] TAP2_IDX = 16'h044A;
  localparam logic [15:0] TAP3_IDX = 16'h044C;
  localparam logic [15:0] TAP4_IDX = 16'h044E;
  localparam logic [15:0] CENTER_IDX = 16'h0450;
  // Control and status words
  localparam logic [15:0] CTRL_IDX = 16'h0460;
  localparam logic [15:0] STATUS_IDX = 16'h0462;

  // Register widths as stored, reserved bits included
  localparam int TAP_REG_W = 16;
  localparam int CENTER_REG_W = 24;
  // Coefficient field widths
  localparam int TAP_W = 12;
  localparam int CENTER_W = 18;
  // Number of stored and of expanded coefficients
  localparam int NUM_STORED = 5;
  localparam int NUM_TAPS = 9;

  // Reset values
  localparam logic [23:0] COEFF_RESET = 24'h000000;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;

  // Control and status field positions
  localparam int CTRL_DUAL_BIT = 0;
  localparam int STATUS_DUAL_BIT = 0;
  localparam int STATUS_APPLIED_BIT = 1;

  // Five stored coefficients, as the filter sees them
  typedef struct packed {
    logic signed [CENTER_W-1:0] center;
    logic signed [TAP_W-1:0] tap4;
    logic signed [TAP_W-1:0] tap3;
    logic signed [TAP_W-1:0] tap2;
    logic signed [TAP_W-1:0] tap1;
  } chan_b_coeff_t;

  // APB request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_t;

endpackage : eq_coeff_pkg

// ### eq_tap_expand.sv
// Expands five stored coefficients into a symmetric nine-tap set.
// Assumes the coefficient input is stable logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module eq_tap_expand
  import eq_coeff_pkg::*;
#(
  parameter int OUT_W = 18
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire chan_b_coeff_t coeff,
  input wire logic enable,
  output logic [NUM_TAPS-1:0][OUT_W-1:0] taps,
  output logic active
);

  // Narrower outputs would clip the centre tap
  if (OUT_W < CENTER_W)
  begin : g_bad_width
    $error("eq_tap_expand: OUT_W below centre tap width");
  end

  // Sign-extended unique values, index 0 is tap one
  logic [NUM_STORED-1:0][OUT_W-1:0] uniq;
  logic [NUM_TAPS-1:0][OUT_W-1:0] taps_d;
  logic [NUM_TAPS-1:0][OUT_W-1:0] taps_q;
  logic active_d;
  logic active_q;

  assign uniq[0] = OUT_W'(coeff.tap1);
  assign uniq[1] = OUT_W'(coeff.tap2);
  assign uniq[2] = OUT_W'(coeff.tap3);
  assign uniq[3] = OUT_W'(coeff.tap4);
  assign uniq[4] = OUT_W'(coeff.center);

  // Tap k and tap 8-k share one value; disabled set reads zero
  for (genvar k = 0; k < NUM_TAPS; k++)
  begin : g_tap
    localparam int U = (k < NUM_STORED) ? k : NUM_TAPS - 1 - k;
    always_comb
    begin
      taps_d[k] = enable ? uniq[U] : '0;
    end
  end

  // Applied flag follows the enable
  always_comb
  begin
    active_d = enable;
  end

  // Register the taps so the filter sees a clean word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      taps_q <= '0;
      active_q <= 1'b0;
    end
    else
    begin
      taps_q <= taps_d;
      active_q <= active_d;
    end
  end

  assign taps = taps_q;
  assign active = active_q;

endmodule : eq_tap_expand
`default_nettype wire

// ### eq_coeff_regs.sv
// APB register block holding the channel B equalizer coefficients.
// Assumes an APB master on pclk; the filter datapath lives elsewhere.
`timescale 1ns/10ps
`default_nettype none
module eq_coeff_regs
  import eq_coeff_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int OUT_W = 18
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_TAPS-1:0][OUT_W-1:0] filt_b_taps,
  output logic filt_b_active,
  output logic dual_mode
);

  // Byte addresses must reach the highest index times four
  if (ADDR_W < 16)
  begin : g_bad_addr
    $error("eq_coeff_regs: ADDR_W too small for register map");
  end

  // Decoded register selector
  typedef enum {
    SEL_TAP1,
    SEL_TAP2,
    SEL_TAP3,
    SEL_TAP4,
    SEL_CENTER,
    SEL_CTRL,
    SEL_STATUS,
    SEL_NONE
  } sel_t;

  // Byte address to register; misaligned words are unmapped
  function automatic sel_t decode(input logic [ADDR_W-1:0] a);
    logic [15:0] idx;
    idx = 16'(a >> 2);
    if (a[1:0] != 2'b00)
      return SEL_NONE;
    case (idx)
      TAP1_IDX: return SEL_TAP1;
      TAP2_IDX: return SEL_TAP2;
      TAP3_IDX: return SEL_TAP3;
      TAP4_IDX: return SEL_TAP4;
      CENTER_IDX: return SEL_CENTER;
      CTRL_IDX: return SEL_CTRL;
      STATUS_IDX: return SEL_STATUS;
      default: return SEL_NONE;
    endcase
  endfunction : decode

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction : merge

  // Stored width per coefficient register
  function automatic logic [31:0] width_mask(input int i);
    if (i == NUM_STORED - 1)
      return 32'(24'hFFFFFF);
    return 32'(16'hFFFF);
  endfunction : width_mask

  // Bus request gathered into one carrier
  apb_req_t req;
  assign req.psel = psel;
  assign req.penable = penable;
  assign req.pwrite = pwrite;
  assign req.paddr = 16'(paddr);
  assign req.pwdata = pwdata;
  assign req.pstrb = pstrb;

  // Current selection, shared by read and write paths
  sel_t sel;
  assign sel = decode(paddr);

  // ------------------------------------------------------------
  // Bus handshake: one wait state so read data leaves a flop
  // ------------------------------------------------------------
  logic ready_d;
  logic ready_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic err_d;
  logic err_q;
  logic xfer; // Transfer completes at this edge

  assign xfer = req.psel && req.penable && ready_q;

  // Next handshake, read data and error state
  always_comb
  begin
    ready_d = 1'b0;
    rdata_d = rdata_q;
    err_d = 1'b0;
    if (req.psel && req.penable && !ready_q)
    begin
      // First access cycle: capture answer, raise ready next
      ready_d = 1'b1;
      err_d = (sel == SEL_NONE);
      rdata_d = req.pwrite ? 32'h00000000 : read_mux(sel);
    end
    else if (xfer)
    begin
      // Answer given; ready drops for the next transfer
      ready_d = 1'b0;
    end
  end

  // Handshake registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ready_q <= 1'b0;
      rdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end
    else
    begin
      ready_q <= ready_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // Handshake outputs; error only shows with ready
  assign pready = ready_q;
  assign pslverr = ready_q && err_q;
  assign prdata = rdata_q;

  // ------------------------------------------------------------
  // Coefficient and control storage
  // ------------------------------------------------------------
  logic [NUM_STORED-1:0][31:0] coeff_d;
  logic [NUM_STORED-1:0][31:0] coeff_q;
  logic [31:0] ctrl_d;
  logic [31:0] ctrl_q;
  logic wr_ok; // Mapped write completing now

  assign wr_ok = xfer && req.pwrite && !err_q;

  // Next stored values; reserved bits are kept writable
  always_comb
  begin
    coeff_d = coeff_q;
    ctrl_d = ctrl_q;
    if (wr_ok)
    begin
      for (int i = 0; i < NUM_STORED; i++)
      begin
        // Coefficient words are masked to their width
        if (sel == sel_t'(i))
          coeff_d[i] = merge(coeff_q[i], req.pwdata, req.pstrb)
            & width_mask(i);
      end
      if (sel == SEL_CTRL)
      begin
        // Only the mode bit exists in control
        ctrl_d = merge(ctrl_q, req.pwdata, req.pstrb)
          & 32'h00000001;
      end
    end
  end

  // Storage registers, all clear at reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_STORED; i++)
        coeff_q[i] <= 32'(COEFF_RESET);
      ctrl_q <= CTRL_RESET;
    end
    else
    begin
      coeff_q <= coeff_d;
      ctrl_q <= ctrl_d;
    end
  end

  // ------------------------------------------------------------
  // Coefficient fields as the filter reads them
  // ------------------------------------------------------------
  chan_b_coeff_t coeff;

  // Low bits hold the signed field; reserved bits ignored
  assign coeff.tap1 = coeff_q[0][TAP_W-1:0];
  assign coeff.tap2 = coeff_q[1][TAP_W-1:0];
  assign coeff.tap3 = coeff_q[2][TAP_W-1:0];
  assign coeff.tap4 = coeff_q[3][TAP_W-1:0];
  assign coeff.center = coeff_q[4][CENTER_W-1:0];

  // Mode bit: high is dual-channel
  logic dual;
  assign dual = ctrl_q[CTRL_DUAL_BIT];

  // Set drives channel B only in dual mode; single mode masks it
  eq_tap_expand #(
    .OUT_W(OUT_W)
  ) u_expand (
    .pclk(pclk),
    .presetn(presetn),
    .coeff(coeff),
    .enable(dual),
    .taps(filt_b_taps),
    .active(filt_b_active)
  );

  assign dual_mode = dual;

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------

  // Status: mode requested and whether the filter now uses the set
  function automatic logic [31:0] status_word(
    input logic d,
    input logic a
  );
    logic [31:0] s;
    s = 32'h00000000;
    s[STATUS_DUAL_BIT] = d;
    s[STATUS_APPLIED_BIT] = a;
    return s;
  endfunction : status_word

  // Read value for a selection; unmapped reads zero
  function automatic logic [31:0] read_mux(input sel_t s);
    case (s)
      SEL_TAP1,
      SEL_TAP2,
      SEL_TAP3,
      SEL_TAP4,
      SEL_CENTER: return coeff_q[int'(s)];
      SEL_CTRL: return ctrl_q;
      SEL_STATUS: return status_word(dual, filt_b_active);
      default: return 32'h00000000;
    endcase
  endfunction : read_mux

endmodule : eq_coeff_regs
`default_nettype wire

// ### eq_coeff_regs_properties.sv
// Checker for the channel B coefficient store.
// Sees only the top module's ports; bound in below.
`timescale 1ns/10ps
`default_nettype none
module eq_coeff_regs_properties
  import eq_coeff_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int OUT_W = 18
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_TAPS-1:0][OUT_W-1:0] filt_b_taps,
  input wire logic filt_b_active,
  input wire logic dual_mode
);
  // One clock domain, so one default for all
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Exactly one wait state, then a one-cycle answer
  rdy_one_wait_a: assert property ($rose(psel && penable) |=> pready)
    else $error("pready not after one wait");
  rdy_single_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  rdy_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  // Misaligned words are refused
  err_misalign_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned not refused");
  err_rdata_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  // Taps live only in dual mode
  mode_follow_a: assert property (1'b1 |=> filt_b_active == $past(dual_mode))
    else $error("active not following mode");
  single_off_a: assert property (!filt_b_active |-> filt_b_taps == '0)
    else $error("taps live in single mode");
  // Mirror pairs share one value
  tap_mirror_a: assert property (filt_b_taps[0] == filt_b_taps[8] &&
    filt_b_taps[1] == filt_b_taps[7] && filt_b_taps[2] == filt_b_taps[6] &&
    filt_b_taps[3] == filt_b_taps[5]) else $error("taps not symmetric");
  tap_sign_a: assert property (&filt_b_taps[0][OUT_W-1:TAP_W-1] ||
    ~|filt_b_taps[0][OUT_W-1:TAP_W-1]) else $error("tap not sign extended");

  // Main scenarios reached
  write_c: cover property (pready && pwrite && !pslverr);
  error_c: cover property (pready && pslverr);
  active_c: cover property ($rose(filt_b_active));
endmodule : eq_coeff_regs_properties
bind eq_coeff_regs eq_coeff_regs_properties #(.ADDR_W(ADDR_W), .OUT_W(OUT_W))
  eq_coeff_regs_properties_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .filt_b_taps(filt_b_taps), .filt_b_active(filt_b_active),
  .dual_mode(dual_mode));
`default_nettype wire

// ### eq_coeff_regs_tb.sv
// Testbench for the channel B coefficient store.
// Drives APB itself; a monitor checks queued results.
`timescale 1ns/10ps
`default_nettype none
module eq_coeff_regs_tb
  import eq_coeff_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic filt_b_active, dual_mode;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [NUM_TAPS-1:0][17:0] filt_b_taps;
  logic [33:0] exp_q[$]; // Write flag, error, data
  logic [33:0] x;
  logic [23:0] shadow [5]; // Expected register contents
  int err_count, samples_checked;

  eq_coeff_regs eq_coeff_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .filt_b_taps(filt_b_taps), .filt_b_active(filt_b_active),
    .dual_mode(dual_mode));

  // 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk

  task wrap_up;
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // Byte address of stored word i; indexes step by two
  function automatic logic [15:0] ba(input int i);
    return 16'((TAP1_IDX + 16'(2 * i)) * 4);
  endfunction : ba

  // One transfer; expectation queued for the monitor
  task apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
    input logic [32:0] ex);
    int n;
    exp_q.push_back({wr, ex});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Sample pready only at rising edges; release at the completing edge
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_count++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Completion monitor: oldest note against what appears
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      x = exp_q.pop_front();
      chk("pslverr", {31'h0, pslverr}, {31'h0, x[32]});
      if (!x[33])
        chk("prdata", prdata, x[31:0]);
    end

  initial
  begin
    int i, k, j;
    logic [31:0] d;
    logic [17:0] e;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    void'($urandom(32'hE6D6));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    for (i = 0; i < 5; i++)
      apb(1'b0, ba(i), 32'h0, 33'h0);
    // Random words; only the register width is kept
    for (i = 0; i < 5; i++)
    begin
      d = $urandom;
      d[11] = 1'b1;
      shadow[i] = (i < 4) ? {8'h00, d[15:0]} : d[23:0];
      apb(1'b1, ba(i), d, 33'h0);
      apb(1'b0, ba(i), 32'h0, {9'h000, shadow[i]});
    end
    // Refused: misaligned and unmapped, nothing stored
    apb(1'b1, 16'h1122, 32'h0, {1'b1, 32'h0});
    apb(1'b0, ba(0), 32'h0, {9'h000, shadow[0]});
    apb(1'b1, 16'h1000, 32'hFFFF, {1'b1, 32'h0});
    apb(1'b0, 16'h1001, 32'h0, {1'b1, 32'h0});
    // Single mode: channel B set has no effect
    repeat (4) @(posedge pclk);
    chk("taps_off", 32'(|filt_b_taps), 32'h0);
    chk("dual_mode", {31'h0, dual_mode}, 32'h0);
    // Dual mode: nine symmetric taps, sign extended
    apb(1'b1, 16'(CTRL_IDX * 4), 32'h1, 33'h0);
    repeat (4) @(posedge pclk);
    chk("active", {31'h0, filt_b_active}, 32'h1);
    chk("dual_mode", {31'h0, dual_mode}, 32'h1);
    // Control reads back; status shows mode and applied set
    apb(1'b0, 16'(CTRL_IDX * 4), 32'h0, 33'h1);
    apb(1'b0, 16'(STATUS_IDX * 4), 32'h0, 33'h3);
    for (k = 0; k < 9; k++)
    begin
      j = (k < 4) ? k : 8 - k;
      e = (j < 4) ? {{6{shadow[j][11]}}, shadow[j][11:0]} : shadow[4][17:0];
      chk("tap", 32'(filt_b_taps[k]), 32'(e));
    end
    // Back to single mode
    apb(1'b1, 16'(CTRL_IDX * 4), 32'h0, 33'h0);
    repeat (4) @(posedge pclk);
    chk("taps_off", 32'(|filt_b_taps), 32'h0);
    chk("active", {31'h0, filt_b_active}, 32'h0);
    wrap_up();
  end
endmodule : eq_coeff_regs_tb
`default_nettype wire
